// ==== core/pmr_pkg.sv ====
package pmr_pkg;
	// ****************
	// Clock and timing
	// ****************
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned DEBOUNCE_STEP_NS = 62_000;
	localparam int unsigned DEBOUNCE_STEP_CYCLES = (DEBOUNCE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned KEY_HOLD_S = 16;
	localparam int unsigned KEY_HOLD_CYCLES = KEY_HOLD_S * CLK_HZ;
	localparam int unsigned BATT_MAX_HZ = 800;
	localparam int unsigned BATT_BASE_CYCLES = CLK_HZ / BATT_MAX_HZ;
	localparam int unsigned THERM_MAX_HZ = 200;
	localparam int unsigned THERM_BASE_CYCLES = CLK_HZ / THERM_MAX_HZ;
	localparam int unsigned TIMER_UNIT_CYCLES = CLK_HZ;
	// ****************
	// Register indices, byte address is four times the index
	// ****************
	localparam logic [7:0] IDX_RATE = 8'h85;
	localparam logic [7:0] IDX_TIMER = 8'h8a;
	localparam logic [7:0] IDX_DEBOUNCE = 8'h8e;
	localparam logic [7:0] IDX_OPTIONS = 8'h8f;
	localparam logic [7:0] IDX_PIN0_FUNC = 8'h90;
	localparam logic [7:0] IDX_PIN0_LEVEL = 8'h91;
	localparam logic [7:0] IDX_PIN1_FUNC = 8'h92;
	// ****************
	// Reset values and writable masks
	// ****************
	localparam logic [7:0] RST_RATE = 8'hb0;
	localparam logic [7:0] RST_TIMER = 8'h00;
	localparam logic [7:0] RST_DEBOUNCE = 8'h40;
	localparam logic [7:0] RST_OPTIONS = 8'h00;
	localparam logic [7:0] RST_PIN_FUNC = 8'h07;
	localparam logic [7:0] RST_PIN_LEVEL = 8'h1a;
	localparam logic [7:0] MASK_RATE = 8'hf4;
	localparam logic [7:0] MASK_THRESHOLD = 8'h7f;
	localparam logic [7:0] MASK_DEBOUNCE = 8'hc0;
	localparam logic [7:0] MASK_OPTIONS = 8'hff;
	localparam logic [7:0] MASK_PIN_FUNC = 8'hc7;
	localparam logic [7:0] MASK_PIN_LEVEL = 8'h1f;
	localparam logic [4:0] LEVEL_MAX_CODE = 5'h1a;
	// ****************
	// Field positions
	// ****************
	localparam int unsigned RATE_PIN0_MODE = 2;
	localparam int unsigned TIMER_STATUS = 7;
	localparam int unsigned OPT_IRQ_WAKE = 7;
	localparam int unsigned OPT_SHORT_SEL = 6;
	localparam int unsigned OPT_SHORT_VAL = 5;
	localparam int unsigned OPT_BUS_PIN = 4;
	localparam int unsigned OPT_KEY_POR = 3;
	localparam int unsigned OPT_OT_SHUT = 2;
	localparam int unsigned OPT_KEEP_VOLT = 1;
	localparam int unsigned OPT_PGOOD_RESTART = 0;
	localparam int unsigned PIN_RISE_EN = 7;
	localparam int unsigned PIN_FALL_EN = 6;
	// ****************
	// Pin function codes
	// ****************
	localparam logic [2:0] FUNC_DRIVE_LOW = 3'h0;
	localparam logic [2:0] FUNC_DRIVE_HIGH = 3'h1;
	localparam logic [2:0] FUNC_DIGITAL_IN = 3'h2;
	localparam logic [2:0] FUNC_LDO_ON = 3'h3;
	localparam logic [2:0] FUNC_FLOAT_FIRST = 3'h5;
	// ****************
	// Synchroniser lanes
	// ****************
	localparam int unsigned SYN_WIDTH = 8;
	localparam int unsigned SYN_VOUT = 0;
	localparam int unsigned SYN_IRQ_N = 1;
	localparam int unsigned SYN_KEY_N = 2;
	localparam int unsigned SYN_PGOOD = 3;
	localparam int unsigned SYN_TEMP = 4;
	localparam int unsigned SYN_BUS_EN_N = 5;
	localparam int unsigned SYN_PIN0 = 6;
	localparam logic [7:0] SYN_IDLE = 8'h2e;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ==== core/pmr_pin_sync.sv ====
`timescale 1ns/100ps
module pmr_pin_sync #(
	parameter int unsigned WIDTH = 8,
	parameter logic [WIDTH-1:0] IDLE = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	logic [WIDTH-1:0] next_level;

	// Per lane: a change counts only once the second and third stage agree
	assign next_level = (s3 & ~(s2 ^ s3)) | (level & (s2 ^ s3));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= IDLE;
			s2 <= IDLE;
			s3 <= IDLE;
			level <= IDLE;
		end else begin
			s1 <= async_in;
			s2 <= s1;
			s3 <= s2;
			level <= next_level;
		end
	end

	assign rise = ~level & next_level;
	assign fall = level & ~next_level;
endmodule // pmr_pin_sync

// ==== core/pmr_rate_tick.sv ====
`timescale 1ns/100ps
module pmr_rate_tick #(
	parameter int unsigned BASE_CYCLES = 31250
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] code,
	output logic tick
);
	logic [31:0] count;
	logic [31:0] limit;

	// Code 3 is the fastest rate; each step down doubles the period
	assign limit = 32'(BASE_CYCLES) << (2'h3 - code);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 32'h0;
			tick <= 1'b0;
		end else if (count >= limit - 32'h1) begin
			count <= 32'h0;
			tick <= 1'b1;
		end else begin
			count <= count + 32'h1;
			tick <= 1'b0;
		end
	end
endmodule // pmr_rate_tick

// ==== core/pmr_misc_regs.sv ====
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/100ps
// How it works
// - Thermistor and pin-0 sample rate 25, 50, 100 or 200 Hz from bits 7:6.
// - Battery voltage and current sample rate 100 to 800 Hz from bits 5:4.
// - Rate bit 2 switches pin-0 bias current on whenever it is set, not only during conversions.
// - Seven-bit timer threshold in bits 6:0; zero stops the timer.
// - Timer status bit 7 rises when the count reaches the threshold.
// - Writing one to the status bit clears it and restarts the count.
// - Output monitor de-bounce of 62 to 248 us, field 7:6, default 01.
// - Option bit 7 lets the interrupt pin wake the device.
// - Option bit 6 picks automatic or software short detection.
// - Option bit 5 is the software short setting when bit 6 selects it.
// - Option bit 4 makes the bus power pin an output or active-low input.
// - Option bit 3 enables power-on reset after 16 s power key hold.
// - Option bit 2 shuts down at over-temperature warning level 3.
// - Option bit 1 clear restores default voltages on wake from sleep.
// - Option bit 0 lets a low on the power-good pin restart a running device.
// - Pin 0 digital input raises events on enabled rising or falling edges.
// - Pin 0 function codes 000 to 100, default 111.
// - Pin 0 codes 101 to 111 float; converter input when its channel is on.
// - Pin 0 level code 0.7 to 3.3 V, default 11010, upper codes reserved.
// - Pin 1 digital input raises events on enabled rising or falling edges.
// - Pin 1 shares codes 000 to 100; upper codes float only.
// - De-bounce register resets on power-on only; others on system reset.
// - Pin-0 current mode is invalid while thermistor source is always on.
module pmr_misc_regs #(
	parameter int unsigned BATT_BASE_CYCLES = pmr_pkg::BATT_BASE_CYCLES,
	parameter int unsigned THERM_BASE_CYCLES = pmr_pkg::THERM_BASE_CYCLES,
	parameter int unsigned TIMER_UNIT_CYCLES = pmr_pkg::TIMER_UNIT_CYCLES,
	parameter int unsigned KEY_HOLD_CYCLES = pmr_pkg::KEY_HOLD_CYCLES,
	parameter int unsigned DEBOUNCE_STEP_CYCLES = pmr_pkg::DEBOUNCE_STEP_CYCLES,
	parameter logic BUS_PIN_INPUT_DEFAULT = 1'b0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic por_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic therm_pin0_sample,
	output logic batt_sample,
	output logic pin0_bias_current_on,
	input wire logic thermistor_source_always_on,
	output logic pin0_current_mode_valid,
	output logic timer_timeout,
	input wire logic vout_monitor_raw,
	output logic vout_monitor_ok,
	input wire logic irq_pin_n,
	output logic wake_request,
	input wire logic auto_short_detect,
	output logic adapter_bus_shorted,
	input wire logic vbus_drive_request,
	output logic bus_power_drive_output,
	output logic bus_power_pin_oe_n,
	input wire logic bus_power_pin_in,
	output logic bus_power_enable_active,
	input wire logic power_key_n,
	output logic key_por_request,
	input wire logic temp_warning3,
	output logic overtemp_shutdown,
	output logic voltage_restore_on_wake,
	input wire logic device_on,
	input wire logic power_good_pin_in,
	output logic power_good_restart,
	input wire logic [1:0] pin_in,
	output logic [1:0] pin_out,
	output logic [1:0] pin_oe_n,
	output logic [1:0] pin_edge_event,
	output logic [1:0] pin_ldo_en,
	input wire logic pin0_adc_enable,
	output logic pin0_converter_input,
	output logic [4:0] pin0_level
);
	import pmr_pkg::*;

	logic [7:0] rate_reg;
	logic [6:0] threshold;
	logic status;
	logic [7:0] debounce_reg;
	logic [7:0] options;
	logic [7:0] pin_func [2];
	logic [7:0] level_reg;
	logic wr_pend;
	logic rd_pend;
	logic [7:0] acc_idx;
	logic accept;
	logic [7:0] read_mux;
	logic [SYN_WIDTH-1:0] syn_level;
	logic [SYN_WIDTH-1:0] syn_rise;
	logic [SYN_WIDTH-1:0] syn_fall;

	// ****************
	// Bus slave
	// ****************
	assign accept = hsel && hready && htrans == HTRANS_NONSEQ;
	assign hresp = 1'b0;

	// Reads take one wait state so a write just before them is seen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			acc_idx <= 8'h00;
			hreadyout <= 1'b1;
			hrdata <= 32'h0;
		end else begin
			wr_pend <= accept && hwrite;
			rd_pend <= accept && !hwrite;
			if (accept) begin
				acc_idx <= (haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0) ? haddr[9:2] : 8'h00;
			end
			if (accept && !hwrite) begin
				hreadyout <= 1'b0;
			end else begin
				hreadyout <= 1'b1;
			end
			if (rd_pend) begin
				hrdata <= {24'h0, read_mux};
			end
		end
	end

	always_comb begin
		case (acc_idx)
			IDX_RATE: read_mux = rate_reg;
			IDX_TIMER: read_mux = {status, threshold};
			IDX_DEBOUNCE: read_mux = debounce_reg;
			IDX_OPTIONS: read_mux = options;
			IDX_PIN0_FUNC: read_mux = pin_func[0];
			IDX_PIN0_LEVEL: read_mux = level_reg;
			IDX_PIN1_FUNC: read_mux = pin_func[1];
			default: read_mux = 8'h00;
		endcase
	end

	// ****************
	// System reset registers
	// ****************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rate_reg <= RST_RATE;
			threshold <= RST_TIMER[6:0];
			options <= RST_OPTIONS | {3'h0, BUS_PIN_INPUT_DEFAULT, 4'h0};
			pin_func[0] <= RST_PIN_FUNC;
			pin_func[1] <= RST_PIN_FUNC;
			level_reg <= RST_PIN_LEVEL;
		end else if (wr_pend) begin
			// Reserved bits are masked off and keep reading zero
			case (acc_idx)
				IDX_RATE: rate_reg <= hwdata[7:0] & MASK_RATE;
				IDX_TIMER: threshold <= hwdata[6:0] & MASK_THRESHOLD[6:0];
				IDX_OPTIONS: options <= hwdata[7:0] & MASK_OPTIONS;
				IDX_PIN0_FUNC: pin_func[0] <= hwdata[7:0] & MASK_PIN_FUNC;
				IDX_PIN0_LEVEL: level_reg <= hwdata[7:0] & MASK_PIN_LEVEL;
				IDX_PIN1_FUNC: pin_func[1] <= hwdata[7:0] & MASK_PIN_FUNC;
				default: ;
			endcase
		end
	end

	// Survives system reset, restored to its default only by power-on reset
	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			debounce_reg <= RST_DEBOUNCE;
		end else if (wr_pend && acc_idx == IDX_DEBOUNCE) begin
			debounce_reg <= hwdata[7:0] & MASK_DEBOUNCE;
		end
	end

	// ****************
	// Sampling rates
	// ****************
	pmr_rate_tick #(
		.BASE_CYCLES(THERM_BASE_CYCLES)
	) u_therm_tick (
		.clk(hclk),
		.rst_n(hresetn),
		.code(rate_reg[7:6]),
		.tick(therm_pin0_sample)
	);

	pmr_rate_tick #(
		.BASE_CYCLES(BATT_BASE_CYCLES)
	) u_batt_tick (
		.clk(hclk),
		.rst_n(hresetn),
		.code(rate_reg[5:4]),
		.tick(batt_sample)
	);

	// ****************
	// Timeout timer
	// ****************
	logic [31:0] unit_cnt;
	logic [6:0] tick_cnt;
	logic timer_run;
	logic timer_clear;
	logic timer_write;
	logic timer_hit;

	assign timer_run = threshold != 7'h0 && !status;
	assign timer_write = wr_pend && acc_idx == IDX_TIMER;
	assign timer_clear = timer_write && hwdata[TIMER_STATUS];
	assign timer_hit = timer_run && unit_cnt == TIMER_UNIT_CYCLES - 1 && tick_cnt + 7'h1 == threshold;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			unit_cnt <= 32'h0;
			tick_cnt <= 7'h0;
		end else if (timer_write || !timer_run) begin
			// Any timer write restarts, so a lowered threshold is never skipped past
			unit_cnt <= 32'h0;
			tick_cnt <= 7'h0;
		end else if (unit_cnt == TIMER_UNIT_CYCLES - 1) begin
			unit_cnt <= 32'h0;
			tick_cnt <= tick_cnt + 7'h1;
		end else begin
			unit_cnt <= unit_cnt + 32'h1;
		end
	end

	// A timeout landing on the clearing write still sets the flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status <= 1'b0;
		end else if (timer_hit) begin
			status <= 1'b1;
		end else if (timer_clear) begin
			status <= 1'b0;
		end
	end
	assign timer_timeout = status;

	// ****************
	// Pin synchronisers
	// ****************
	pmr_pin_sync #(
		.WIDTH(SYN_WIDTH),
		.IDLE(SYN_IDLE)
	) u_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.async_in({pin_in, bus_power_pin_in, temp_warning3, power_good_pin_in, power_key_n, irq_pin_n,
			vout_monitor_raw}),
		.level(syn_level),
		.rise(syn_rise),
		.fall(syn_fall)
	);

	// ****************
	// Output monitor de-bounce
	// ****************
	logic [15:0] dbc_cnt;
	logic [15:0] dbc_limit;

	assign dbc_limit = 16'(DEBOUNCE_STEP_CYCLES * ({30'h0, debounce_reg[7:6]} + 32'h1));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dbc_cnt <= 16'h0;
			vout_monitor_ok <= 1'b0;
		end else if (syn_level[SYN_VOUT] == vout_monitor_ok) begin
			dbc_cnt <= 16'h0;
		end else if (dbc_cnt >= dbc_limit - 16'h1) begin
			dbc_cnt <= 16'h0;
			vout_monitor_ok <= syn_level[SYN_VOUT];
		end else begin
			dbc_cnt <= dbc_cnt + 16'h1;
		end
	end

	// ****************
	// Power key hold
	// ****************
	logic [31:0] key_cnt;

	// Fires once per hold; the key must be released, or option bit 3 cleared, before it can fire again
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			key_cnt <= 32'h0;
			key_por_request <= 1'b0;
		end else if (syn_level[SYN_KEY_N] || !options[OPT_KEY_POR]) begin
			key_cnt <= 32'h0;
			key_por_request <= 1'b0;
		end else if (key_cnt < KEY_HOLD_CYCLES) begin
			key_cnt <= key_cnt + 32'h1;
			key_por_request <= key_cnt == KEY_HOLD_CYCLES - 1;
		end else begin
			key_por_request <= 1'b0;
		end
	end

	// ****************
	// Option outputs
	// ****************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_request <= 1'b0;
			adapter_bus_shorted <= 1'b0;
			bus_power_drive_output <= 1'b0;
			bus_power_pin_oe_n <= 1'b1;
			bus_power_enable_active <= 1'b0;
			overtemp_shutdown <= 1'b0;
			voltage_restore_on_wake <= 1'b1;
			power_good_restart <= 1'b0;
			pin0_bias_current_on <= 1'b0;
			pin0_current_mode_valid <= 1'b0;
		end else begin
			wake_request <= options[OPT_IRQ_WAKE] && syn_fall[SYN_IRQ_N];
			adapter_bus_shorted <= options[OPT_SHORT_SEL] ? options[OPT_SHORT_VAL] : auto_short_detect;
			bus_power_drive_output <= vbus_drive_request && !options[OPT_BUS_PIN];
			bus_power_pin_oe_n <= options[OPT_BUS_PIN];
			bus_power_enable_active <= options[OPT_BUS_PIN] && !syn_level[SYN_BUS_EN_N];
			overtemp_shutdown <= options[OPT_OT_SHUT] && syn_level[SYN_TEMP];
			voltage_restore_on_wake <= !options[OPT_KEEP_VOLT];
			power_good_restart <= options[OPT_PGOOD_RESTART] && device_on && syn_fall[SYN_PGOOD];
			pin0_bias_current_on <= rate_reg[RATE_PIN0_MODE];
			// One current source serves both pins
			pin0_current_mode_valid <= rate_reg[RATE_PIN0_MODE] && !thermistor_source_always_on;
		end
	end

	// ****************
	// General-purpose pins
	// ****************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_out <= 2'h0;
			pin_oe_n <= 2'h3;
			pin_edge_event <= 2'h0;
			pin_ldo_en <= 2'h0;
			pin0_converter_input <= 1'b0;
			pin0_level <= LEVEL_MAX_CODE;
		end else begin
			for (int p = 0; p < 2; p++) begin
				pin_out[p] <= pin_func[p][2:0] == FUNC_DRIVE_HIGH;
				pin_oe_n[p] <= pin_func[p][2:1] != 2'h0;
				pin_ldo_en[p] <= pin_func[p][2:0] == FUNC_LDO_ON;
				pin_edge_event[p] <= pin_func[p][2:0] == FUNC_DIGITAL_IN &&
					((pin_func[p][PIN_RISE_EN] && syn_rise[SYN_PIN0 + p]) ||
					(pin_func[p][PIN_FALL_EN] && syn_fall[SYN_PIN0 + p]));
			end
			pin0_converter_input <= pin_func[0][2:0] >= FUNC_FLOAT_FIRST && pin0_adc_enable;
			// Reserved level codes are held at the top step
			pin0_level <= (level_reg[4:0] > LEVEL_MAX_CODE) ? LEVEL_MAX_CODE : level_reg[4:0];
		end
	end
endmodule // pmr_misc_regs

// ==== verification/pmr_misc_regs_monitor.sv ====
`timescale 1ns/100ps
module pmr_misc_regs_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [1:0] pin_out,
	input wire logic [1:0] pin_oe_n,
	input wire logic [1:0] pin_edge_event,
	input wire logic [1:0] pin_ldo_en,
	input wire logic pin0_adc_enable,
	input wire logic pin0_converter_input,
	input wire logic [4:0] pin0_level,
	input wire logic timer_timeout,
	input wire logic bus_power_drive_output,
	input wire logic bus_power_pin_oe_n,
	input wire logic bus_power_enable_active,
	input wire logic power_key_n,
	input wire logic key_por_request,
	input wire logic temp_warning3,
	input wire logic overtemp_shutdown,
	input wire logic irq_pin_n,
	input wire logic wake_request
);
	import pmr_pkg::*;
	logic wr_q, clr_q, clr_q2;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ****
	// Timer clear writes, followed into the data phase
	// ****
	// Two stages, though the status output is the register itself and does not lag it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			clr_q <= 1'b0;
			clr_q2 <= 1'b0;
		end else begin
			wr_q <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite && haddr == 32'h228;
			clr_q <= wr_q && hwdata[7];
			clr_q2 <= clr_q;
		end
	end
	a_drive_mode_only: assert property ((pin_out & (pin_oe_n | pin_ldo_en)) == 2'b00)
		else $error("pin driven high outside drive mode");
	a_edge_input_only: assert property (|pin_edge_event |-> (pin_edge_event & (~pin_oe_n | pin_ldo_en)) == 2'b00)
		else $error("edge event outside input mode");
	a_adc_float: assert property (pin0_converter_input |-> $past(pin0_adc_enable) && pin_oe_n[0] && !pin_ldo_en[0])
		else $error("converter input without float and enable");
	a_level_cap: assert property (pin0_level <= 5'h1a)
		else $error("reserved level code reached the pin");
	a_bus_pin_dir: assert property (!(bus_power_drive_output && bus_power_pin_oe_n) && !(bus_power_enable_active && !bus_power_pin_oe_n))
		else $error("bus power pin direction mixed");
	a_timeout_sticky: assert property ($fell(timer_timeout) |-> clr_q || clr_q2)
		else $error("timeout status fell without a clear write");
	a_key_held: assert property (key_por_request |-> !$past(power_key_n, 5) ##1 !key_por_request)
		else $error("key reset without a held key");
	a_overtemp_quiet: assert property (!temp_warning3 [*6] |-> !overtemp_shutdown)
		else $error("shutdown without temperature warning");
	a_wake_pulse: assert property (wake_request |-> !$past(irq_pin_n, 3) ##1 !wake_request)
		else $error("wake without a low interrupt pin");
endmodule // pmr_misc_regs_monitor
bind pmr_misc_regs pmr_misc_regs_monitor u_monitor (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hwdata, .pin_out, .pin_oe_n, .pin_edge_event, .pin_ldo_en, .pin0_adc_enable, .pin0_converter_input,
	.pin0_level, .timer_timeout, .bus_power_drive_output, .bus_power_pin_oe_n, .bus_power_enable_active,
	.power_key_n, .key_por_request, .temp_warning3, .overtemp_shutdown, .irq_pin_n, .wake_request);

// ==== verification/pmr_board_model.sv ====
`timescale 1ns/100ps
module pmr_board_model (
	input wire logic [1:0] pin_out,
	input wire logic [1:0] pin_oe_n,
	input wire logic [1:0] ext_level,
	input wire logic bus_drive,
	input wire logic bus_oe_n,
	input wire logic bus_ext_n,
	input wire logic key_press,
	input wire logic pgood_pull_low,
	output logic [1:0] pin_in,
	output logic bus_pin,
	output logic power_key_n,
	output logic power_good_pin
);
	// A released pin shows the board level, never the last value the device drove
	assign pin_in = (pin_oe_n & ext_level) | (~pin_oe_n & pin_out);
	assign bus_pin = bus_oe_n ? bus_ext_n : bus_drive;
	assign power_key_n = !key_press;
	assign power_good_pin = !pgood_pull_low;
endmodule // pmr_board_model

// ==== verification/pmr_misc_regs_tb_top.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %0t mismatch", $time); end end
module pmr_misc_regs_tb_top;
	import pmr_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, por_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
	logic [1:0] htrans = 2'h0, ext_level = 2'h0, pin_in, pin_out, pin_oe_n, pin_edge_event, pin_ldo_en;
	logic [2:0] hsize = 3'h2;
	logic [4:0] pin0_level;
	logic thermistor_source_always_on = 1'b0, vout_monitor_raw = 1'b0, irq_pin_n = 1'b1, auto_short_detect = 1'b0;
	logic vbus_drive_request = 1'b1, temp_warning3 = 1'b0, device_on = 1'b1, pin0_adc_enable = 1'b1;
	logic bus_ext_n = 1'b1, key_press = 1'b0, pgood_pull_low = 1'b0;
	logic therm_pin0_sample, batt_sample, pin0_bias_current_on, pin0_current_mode_valid, timer_timeout;
	logic vout_monitor_ok, wake_request, adapter_bus_shorted, bus_power_drive_output, bus_power_pin_oe_n;
	logic bus_power_pin_in, bus_power_enable_active, power_key_n, key_por_request, overtemp_shutdown;
	logic voltage_restore_on_wake, power_good_pin_in, power_good_restart, pin0_converter_input;
	wire hready = hreadyout;
	int n_fail, n_compared, n_t, n_b, n_w, n_k, n_g, c, s0, s1, s2;
	int n_ev [2];
	logic [7:0] idx_t [7] = '{8'h85, 8'h8a, 8'h8e, 8'h8f, 8'h90, 8'h91, 8'h92};
	logic [7:0] rst_t [7] = '{8'hb0, 8'h00, 8'h40, 8'h00, 8'h07, 8'h1a, 8'h07};
	logic [7:0] msk_t [7] = '{8'hf4, 8'h7f, 8'hc0, 8'hff, 8'hc7, 8'h1f, 8'hc7};
	logic [1:0] en_t [4] = '{2'b11, 2'b10, 2'b01, 2'b00};
	logic [7:0] opt_t [3] = '{8'h8d, 8'h10, 8'h41};
	pmr_misc_regs #(.BATT_BASE_CYCLES(4), .THERM_BASE_CYCLES(8), .TIMER_UNIT_CYCLES(4), .KEY_HOLD_CYCLES(20),
		.DEBOUNCE_STEP_CYCLES(5)) uut (.hclk, .hresetn, .por_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hresp, .hrdata, .therm_pin0_sample, .batt_sample, .pin0_bias_current_on,
		.thermistor_source_always_on, .pin0_current_mode_valid, .timer_timeout, .vout_monitor_raw, .vout_monitor_ok,
		.irq_pin_n, .wake_request, .auto_short_detect, .adapter_bus_shorted, .vbus_drive_request,
		.bus_power_drive_output, .bus_power_pin_oe_n, .bus_power_pin_in, .bus_power_enable_active, .power_key_n,
		.key_por_request, .temp_warning3, .overtemp_shutdown, .voltage_restore_on_wake, .device_on,
		.power_good_pin_in, .power_good_restart, .pin_in, .pin_out, .pin_oe_n, .pin_edge_event, .pin_ldo_en,
		.pin0_adc_enable, .pin0_converter_input, .pin0_level);
	pmr_board_model board (.pin_out, .pin_oe_n, .ext_level, .bus_drive(bus_power_drive_output),
		.bus_oe_n(bus_power_pin_oe_n), .bus_ext_n, .key_press, .pgood_pull_low, .pin_in, .bus_pin(bus_power_pin_in),
		.power_key_n, .power_good_pin(power_good_pin_in));
	initial forever #20 hclk = ~hclk;
	always @(posedge hclk) begin
		n_t += therm_pin0_sample;
		n_b += batt_sample;
		n_w += wake_request;
		n_k += key_por_request;
		n_g += power_good_restart;
		n_ev[0] += pin_edge_event[0];
		n_ev[1] += pin_edge_event[1];
	end
	// ****
	// Bus access
	// ****
	task automatic hs;
		int n;
		n = 0;
		do @(posedge hclk);
		while (hreadyout !== 1'b1 && ++n < 50);
		if (n >= 50) n_fail++;
	endtask
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		hs();
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		hs();
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		`CHK(q, {24'h0, e})
	endtask
	task automatic wait_to(output int k);
		k = 0;
		while (timer_timeout !== 1'b1 && k < 200) begin
			@(posedge hclk);
			k++;
		end
	endtask
	task automatic report_and_stop;
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge hclk);
		n_fail++;
		report_and_stop;
	end
	// ****
	// Scenarios
	// ****
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		por_n <= 1'b1;
		foreach (idx_t[i]) rd(idx_t[i], rst_t[i]);
		foreach (idx_t[i]) begin
			wr(idx_t[i], 8'hff);
			rd(idx_t[i], msk_t[i]);
		end
		wr(8'h86, 8'hff);
		rd(8'h86, 8'h00);
		repeat (2) @(posedge hclk);
		`CHK(adapter_bus_shorted, 1'b1)
		`CHK(bus_power_pin_oe_n, 1'b1)
		`CHK(voltage_restore_on_wake, 1'b0)
		`CHK(pin0_level, 5'h1a)
		`CHK(pin0_converter_input, 1'b1)
		pin0_adc_enable <= 1'b0;
		`CHK(pin0_bias_current_on, 1'b1)
		`CHK(pin0_current_mode_valid, 1'b1)
		thermistor_source_always_on <= 1'b1;
		repeat (3) @(posedge hclk);
		`CHK(pin0_current_mode_valid, 1'b0)
		`CHK(pin0_converter_input, 1'b0)
		pin0_adc_enable <= 1'b1;
		wr(8'h8a, 8'h03);
		wait_to(c);
		`CHK(c inside {[10:15]}, 1'b1)
		rd(8'h8a, 8'h83);
		wr(8'h8a, 8'h83);
		repeat (2) @(posedge hclk);
		`CHK(timer_timeout, 1'b0)
		wait_to(c);
		`CHK(c inside {[8:15]}, 1'b1)
		wr(8'h8a, 8'h80);
		repeat (60) @(posedge hclk);
		`CHK(timer_timeout, 1'b0)
		for (int k = 0; k < 4; k++) begin
			wr(8'h85, {k[1:0], k[1:0], 4'h0});
			repeat (8) @(posedge hclk);
			s0 = n_t;
			s1 = n_b;
			repeat (256) @(posedge hclk);
			`CHK((n_t - s0) inside {[(4 << k) - 1:(4 << k) + 1]}, 1'b1)
			`CHK((n_b - s1) inside {[(8 << k) - 1:(8 << k) + 1]}, 1'b1)
		end
		for (int p = 0; p < 2; p++) begin
			for (int f = 0; f < 5; f++) begin
				wr(8'h90 + 8'(2 * p), {5'h18, f[2:0]});
				repeat (2) @(posedge hclk);
				`CHK(pin_oe_n[p], f > 1)
				`CHK(pin_out[p], f == 1)
				`CHK(pin_ldo_en[p], f == 3)
			end
			foreach (en_t[j]) begin
				wr(8'h90 + 8'(2 * p), {en_t[j], 6'h02});
				repeat (8) @(posedge hclk);
				s0 = n_ev[p];
				ext_level[p] <= 1'b1;
				repeat (8) @(posedge hclk);
				ext_level[p] <= 1'b0;
				repeat (8) @(posedge hclk);
				`CHK(n_ev[p] - s0, int'(en_t[j][1]) + int'(en_t[j][0]))
			end
		end
		auto_short_detect <= 1'b1;
		foreach (opt_t[j]) begin
			wr(8'h8f, opt_t[j]);
			device_on <= (j != 2);
			s0 = n_w;
			s1 = n_k;
			s2 = n_g;
			irq_pin_n <= 1'b0;
			key_press <= 1'b1;
			temp_warning3 <= 1'b1;
			pgood_pull_low <= 1'b1;
			bus_ext_n <= 1'b0;
			repeat (40) @(posedge hclk);
			`CHK(n_w - s0, int'(opt_t[j][7]))
			`CHK(n_k - s1, int'(opt_t[j][3]))
			`CHK(n_g - s2, int'(opt_t[j][0] && device_on))
			`CHK(overtemp_shutdown, opt_t[j][2])
			`CHK(bus_power_drive_output, !opt_t[j][4])
			`CHK(bus_power_enable_active, opt_t[j][4])
			`CHK(voltage_restore_on_wake, !opt_t[j][1])
			`CHK(adapter_bus_shorted, opt_t[j][6] ? opt_t[j][5] : 1'b1)
			irq_pin_n <= 1'b1;
			key_press <= 1'b0;
			temp_warning3 <= 1'b0;
			pgood_pull_low <= 1'b0;
			bus_ext_n <= 1'b1;
			repeat (10) @(posedge hclk);
		end
		wr(8'h8e, 8'hc0);
		vout_monitor_raw <= 1'b1;
		repeat (8) @(posedge hclk);
		`CHK(vout_monitor_ok, 1'b0)
		repeat (30) @(posedge hclk);
		`CHK(vout_monitor_ok, 1'b1)
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rd(8'h8e, 8'hc0);
		rd(8'h85, 8'hb0);
		por_n <= 1'b0;
		repeat (2) @(posedge hclk);
		por_n <= 1'b1;
		rd(8'h8e, 8'h40);
		report_and_stop;
	end
endmodule // pmr_misc_regs_tb_top
